// File: dv/adcsc_host_model.sv
// Purpose: serial bus master in front of the converter control block
// Assumes: core clock as time base, link clock of 125 ns, mode 0 framing
// Notes:   released data line reads back inverted, never a stale copy
`timescale 1ns/1ps
module adcsc_host_model (
	input  wire logic clk_i,
	input  wire logic dout_i,
	input  wire logic dout_oe_i,
	input  wire logic strobe_i,
	output logic      cs_n_o,
	output logic      sclk_o,
	output logic      din_o
);
	logic line;
	logic rxb [1:64];
	logic stb [1:64];

	assign line = dout_oe_i ? dout_i : ~dout_i;

	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		din_o  = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic select(input logic lvl);
		wait_cyc(2);
		cs_n_o = lvl;
	endtask

	// clock idles low between calls; frames stay far under the droop limit
	task automatic shift(input logic [63:0] tx, input int n);
		for (int k = 1; k <= n; k++) begin
			din_o = tx[n-k];
			wait_cyc(13);
			rxb[k] = line;
			stb[k] = strobe_i;
			sclk_o = 1'b1;
			wait_cyc(12);
			sclk_o = 1'b0;
		end
	endtask
endmodule

// File: dv/tb_adcsc_ctrl.sv
// Purpose: self-checking bench for the serial conversion control block
// Assumes: comparator follows a fixed analog code, 200 MHz core clock
// Notes:   host model drives the serial pins, bench drives the rest
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_adcsc_ctrl;
	import adcsc_pkg::*;

	localparam logic [2:0] SELC [4] = '{3'h1, 3'h5, 3'h2, 3'h6};

	logic                core_clk;
	logic                arst_n;
	logic                cs_n;
	logic                sclk;
	logic                din;
	logic                shutdown_pin_n_n;
	logic                sh_float;
	logic                comparator;
	logic                dout;
	logic                dout_oe;
	logic                strobe;
	logic                strobe_oe;
	logic [1:0]          mux_pos;
	logic [1:0]          mux_neg;
	logic                mux_com;
	logic                unipolar;
	logic [SAR_BITS-1:0] trial;
	logic                full_pd;
	logic                fast_pd;
	logic                hw_shut;
	logic                comp_int;
	logic                int_mode;
	logic                track;
	logic [11:0]         target;
	logic                uni;
	logic [15:0]         got;
	logic [15:0]         ev;
	logic [12:0]         g1;
	logic [12:0]         g2;
	int                  num_errors;
	int                  num_checks;
	int                  cycles;
	int                  cnt;

	// analog side: keep a trial bit while the trial code is not above the input
	assign comparator = (trial <= target);

	adcsc_ctrl uut (
		.core_clk_i         (core_clk),
		.arst_n_i           (arst_n),
		.cs_n_i             (cs_n),
		.sclk_i             (sclk),
		.din_i              (din),
		.shutdown_pin_n_i   (shutdown_pin_n_n),
		.shutdown_float_i   (sh_float),
		.comparator_i       (comparator),
		.dout_o             (dout),
		.dout_oe_o          (dout_oe),
		.serial_strobe_o    (strobe),
		.serial_strobe_oe_o (strobe_oe),
		.track_hold_o       (track),
		.mux_pos_o          (mux_pos),
		.mux_neg_o          (mux_neg),
		.mux_neg_com_o      (mux_com),
		.unipolar_o         (unipolar),
		.sar_trial_o        (trial),
		.full_power_down_o  (full_pd),
		.fast_power_down_o  (fast_pd),
		.hw_shutdown_o      (hw_shut),
		.comp_internal_o    (comp_int),
		.int_clock_mode_o   (int_mode)
	);

	adcsc_host_model host (
		.clk_i     (core_clk),
		.dout_i    (dout),
		.dout_oe_i (dout_oe),
		.strobe_i  (strobe),
		.cs_n_o    (cs_n),
		.sclk_o    (sclk),
		.din_o     (din)
	);

	////////////////////////////////////////////////////////////////////////////////
	// bipolar flips the msb: offset binary to twos complement
	function automatic logic [15:0] exp_res(input logic u);
		exp_res = {1'b0, ~u ^ target[11], target[10:0], 3'b000};
	endfunction

	task automatic final_report;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic ext_conv(input logic [7:0] ctrl, input int lead, input logic [15:0] er,
			input logic [15:0] es);
		logic [15:0] sg;
		host.select(1'b0);
		host.shift({40'h0, ctrl, 16'h0}, 24 + lead);
		for (int i = 0; i < 16; i++) begin
			got[15-i] = host.rxb[lead+9+i];
			sg[15-i]  = host.stb[lead+9+i];
		end
		host.select(1'b1);
		`CHK("result", er, got)
		`CHK("strobe", es, sg)
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 40000) begin
			num_errors++;
			$display("MISMATCH timeout expected done seen running");
			final_report();
		end
	end

	initial begin
		arst_n   = 1'b0;
		shutdown_pin_n_n   = 1'b1;
		sh_float = 1'b1;
		target   = 12'hb2d;
		uni      = 1'b0;
		repeat (12) @(posedge core_clk);
		#1 arst_n = 1'b1;
		host.wait_cyc(30);
		`CHK("por_strobe", 2'h3, {strobe, strobe_oe})
		`CHK("por_int", 1'b1, int_mode)
		// start bit inside the reset interval must be ignored
		ext_conv(8'h9f, 0, 16'h0, 16'hffff);
		host.wait_cyc(1500);
		for (int i = 0; i < 4; i++) begin
			for (int s = 0; s < 2; s++) begin
				uni = i[0] ^ s[0];
				ext_conv({1'b1, SELC[i], uni, s[0], PD_EXT}, i, exp_res(uni), 16'h8000);
				`CHK("mux_pos", i[1:0], mux_pos)
				`CHK("mux_com", s[0], mux_com)
				if (s == 0) `CHK("mux_neg", i[1:0] ^ 2'h1, mux_neg)
				`CHK("unipolar", uni, unipolar)
			end
		end
		host.wait_cyc(8);
		`CHK("ext_release", 2'h0, {dout_oe, strobe_oe})
		host.select(1'b0);
		host.wait_cyc(10);
		`CHK("ext_strobe_low", 2'h1, {strobe, strobe_oe})
		ext_conv({5'h13, 1'b1, PD_FAST}, 0, exp_res(1'b1), 16'h8000);
		`CHK("fast_pd", 2'h1, {full_pd, fast_pd})
		ext_conv({5'h13, 1'b1, PD_FULL}, 0, exp_res(1'b1), 16'h8000);
		`CHK("full_pd", 2'h2, {full_pd, fast_pd})
		ext_conv(8'h9f, 0, exp_res(1'b1), 16'h8000);
		`CHK("pd_clear", 2'h0, {full_pd, fast_pd})
		// back to back frames, 15 and 16 clocks, select held low
		for (int p = 15; p <= 16; p++) begin
			host.select(1'b0);
			host.shift(({56'h0, 8'h9f} << (p + 16)) | ({56'h0, 8'hd7} << 16), p + 24);
			for (int i = 0; i < 13; i++) begin
				g1[12-i] = host.rxb[9+i];
				g2[12-i] = host.rxb[p+9+i];
			end
			host.select(1'b1);
			ev = exp_res(1'b1);
			`CHK("b2b_first", ev[15:3], g1)
			ev = exp_res(1'b0);
			`CHK("b2b_second", ev[15:3], g2)
			`CHK("b2b_mux", 2'h1, mux_pos)
		end
		// internal clock: host keeps the clock low while converting
		host.select(1'b0);
		host.shift({56'h0, 8'hae} >> 2, 6);
		`CHK("track_on", 1'b1, track)
		host.shift({56'h0, 8'hae}, 2);
		host.wait_cyc(8);
		`CHK("int_strobe_low", 3'h2, {strobe, int_mode, track})
		host.select(1'b1);
		host.wait_cyc(8);
		`CHK("int_deselect", 2'h1, {dout_oe, strobe_oe})
		host.select(1'b0);
		cnt = 0;
		while (strobe !== 1'b1 && cnt < 3000) begin
			host.wait_cyc(1);
			cnt++;
		end
		`CHK("int_low_time", 1'b1, (cnt + 20 <= int'(INT_LOW_MAX_CYC)))
		host.shift(64'h0, 16);
		for (int i = 0; i < 15; i++) got[14-i] = host.rxb[2+i];
		ev = exp_res(1'b1);
		`CHK("int_result", ev[14:0], got[14:0])
		`CHK("int_mux", 2'h2, mux_pos)
		host.select(1'b1);
		// toggled select mid conversion rearms the start bit
		host.select(1'b0);
		host.shift({56'h0, 8'hae}, 8);
		host.wait_cyc(8);
		host.select(1'b1);
		ext_conv(8'h9f, 0, exp_res(1'b1), 16'h8000);
		`CHK("comp_float", 1'b0, comp_int)
		sh_float = 1'b0;
		host.wait_cyc(10);
		`CHK("comp_high", 1'b1, comp_int)
		// driven shutdown pin slows the internal conversion clock
		host.select(1'b0);
		host.shift({56'h0, 8'hae}, 8);
		host.wait_cyc(8);
		cnt = 0;
		while (strobe !== 1'b1 && cnt < 12000) begin
			host.wait_cyc(1);
			cnt++;
		end
		`CHK("int_slow", 1'b1, (cnt > int'(INT_LOW_MAX_CYC)) && (cnt < 12000))
		host.select(1'b0);
		host.shift({56'h0, 8'h9f}, 10);
		shutdown_pin_n_n = 1'b0;
		host.wait_cyc(10);
		`CHK("shutdown", 3'h4, {hw_shut, dout_oe, strobe_oe})
		final_report();
	end
endmodule

// File: hw/adcsc_ctrl.sv
// Purpose: serial control and conversion sequencing of a four input sar converter
// Assumes: analog side gives comparator_i for the current sar_trial_o
// Notes:   shutdown_float_i comes from an analog float detector on the shutdown pin
`timescale 1ns/1ps
module adcsc_ctrl
	import adcsc_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        arst_n_i,
	input  wire logic        cs_n_i,
	input  wire logic        sclk_i,
	input  wire logic        din_i,
	input  wire logic        shutdown_pin_n_i,
	input  wire logic        shutdown_float_i,
	input  wire logic        comparator_i,
	output logic             dout_o,
	output logic             dout_oe_o,
	output logic             serial_strobe_o,
	output logic             serial_strobe_oe_o,
	output logic             track_hold_o,
	output logic [1:0]       mux_pos_o,
	output logic [1:0]       mux_neg_o,
	output logic             mux_neg_com_o,
	output logic             unipolar_o,
	output logic [SAR_BITS-1:0] sar_trial_o,
	output logic             full_power_down_o,
	output logic             fast_power_down_o,
	output logic             hw_shutdown_o,
	output logic             comp_internal_o,
	output logic             int_clock_mode_o
);

	////////////////////////////////////////////////////////////////////////////
	// functions

	function automatic logic [SAR_BITS-1:0] sar_step(input logic [SAR_BITS-1:0] s,
			input logic [3:0] n, input logic c);
		logic [SAR_BITS-1:0] r;
		logic [3:0]          i;
		i = 4'(SAR_BITS - 1) - n;
		r = s;
		r[i] = c;
		if (i != 4'h0) begin
			r[i - 4'h1] = 1'b1;
		end
		return r;
	endfunction

	// offset binary to twos complement by msb flip
	function automatic logic [SAR_BITS-1:0] fmt(input logic [SAR_BITS-1:0] s, input logic uni);
		return {s[SAR_BITS-1] ^ ~uni, s[SAR_BITS-2:0]};
	endfunction

	// {pos, neg, neg_is_com}
	function automatic logic [4:0] chan(input logic [2:0] sel, input logic se);
		logic [4:0] r;
		r = 5'h01;
		case (sel)
			3'h1: r = se ? 5'h01 : 5'h02;
			3'h5: r = se ? 5'h09 : 5'h08;
			3'h2: r = se ? 5'h11 : 5'h16;
			3'h6: r = se ? 5'h19 : 5'h1c;
			default: r = 5'h01;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// reset and pin sampling

	logic rst_meta_reg;
	logic rst_n_reg;

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg    <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg    <= rst_meta_reg;
		end
	end

	logic cs_n_s;
	logic sclk_s;
	logic din_s;
	logic shutdown_pin_n_n_s;
	logic float_s;

	adcsc_pin_sync #(
		.W       (5),
		.RST_VAL (5'h12)
	) u_sync (
		.clk_i   (core_clk_i),
		.rst_n_i (rst_n_reg),
		.d_i     ({cs_n_i, sclk_i, din_i, shutdown_pin_n_i, shutdown_float_i}),
		.q_o     ({cs_n_s, sclk_s, din_s, shutdown_pin_n_n_s, float_s})
	);

	logic sclk_d_reg;
	logic cs_d_reg;

	always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			sclk_d_reg <= 1'b0;
			cs_d_reg   <= 1'b1;
		end else begin
			sclk_d_reg <= sclk_s;
			cs_d_reg   <= cs_n_s;
		end
	end

	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic cs_rise;
	assign sclk_rise = sclk_s & ~sclk_d_reg;
	assign sclk_fall = ~sclk_s & sclk_d_reg;
	assign cs_fall   = ~cs_n_s & cs_d_reg;
	assign cs_rise   = cs_n_s & ~cs_d_reg;

	////////////////////////////////////////////////////////////////////////////
	// shared state

	adcsc_state_t        state_reg;
	logic [7:0]          ctrl_reg;
	logic [3:0]          rx_cnt_reg;
	logic                rx_active_reg;
	logic                launch_reg;
	logic                rearm_reg;
	logic                ext_mode_reg;
	logic                pd_req_reg;
	logic [3:0]          conv_cnt_reg;
	logic [FRAME_BITS-1:0] out_shift_reg;
	logic [4:0]          out_cnt_reg;
	logic [9:0]          div_cnt_reg;
	logic [11:0]         por_cnt_reg;

	logic powered;
	logic accept_rx;
	logic start_ok;
	logic start_bit;
	logic conv_go;
	logic use_ext;
	logic tick;
	logic step_ev;
	logic done_ev;
	logic [9:0] div_top;

	assign powered   = (state_reg != ST_POR) && (state_reg != ST_SHUT) && shutdown_pin_n_n_s;
	assign accept_rx = sclk_rise & ~cs_n_s & powered;
	assign start_ok  = (state_reg == ST_IDLE) || rearm_reg
	                   || (out_cnt_reg >= 5'(REARM_BITS));
	assign start_bit = accept_rx & ~rx_active_reg & din_s & start_ok;
	assign conv_go   = launch_reg & sclk_fall & powered;
	// power-down codes keep the previous clock mode for this conversion
	assign use_ext   = ctrl_reg[1] ? ctrl_reg[0] : ext_mode_reg;
	assign div_top   = float_s ? INT_DIV_FLOAT : INT_DIV_HIGH;
	assign tick      = (state_reg == ST_INT) && (div_cnt_reg == div_top - 10'h1);
	assign step_ev   = ~conv_go & (((state_reg == ST_EXT) & sclk_fall)
	                   | ((state_reg == ST_INT) & tick));
	assign done_ev   = step_ev & (conv_cnt_reg == 4'(SAR_BITS - 1));

	////////////////////////////////////////////////////////////////////////////
	// control byte reception

	always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			ctrl_reg      <= 8'h00;
			rx_cnt_reg    <= 4'h0;
			rx_active_reg <= 1'b0;
			launch_reg    <= 1'b0;
		end else if (!powered || cs_rise) begin
			rx_active_reg <= 1'b0;
			launch_reg    <= 1'b0;
		end else begin
			if (conv_go) begin
				launch_reg <= 1'b0;
			end
			if (accept_rx && rx_active_reg) begin
				ctrl_reg   <= {ctrl_reg[6:0], din_s};
				rx_cnt_reg <= rx_cnt_reg + 4'h1;
				if (rx_cnt_reg == 4'(CTRL_BITS - 1)) begin
					rx_active_reg <= 1'b0;
					launch_reg    <= 1'b1;
				end
			end else if (start_bit) begin
				ctrl_reg      <= 8'h01;
				rx_cnt_reg    <= 4'h1;
				rx_active_reg <= 1'b1;
			end
		end
	end

	// track while the last three control bits arrive
	always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			track_hold_o <= 1'b0;
		end else begin
			track_hold_o <= rx_active_reg && (rx_cnt_reg >= 4'(TRACK_FROM));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer

	always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			state_reg   <= ST_POR;
			por_cnt_reg <= 12'h000;
		end else if (!shutdown_pin_n_n_s) begin
			state_reg <= ST_SHUT;
		end else begin
			case (state_reg)
				ST_POR: begin
					por_cnt_reg <= por_cnt_reg + 12'h001;
					if (por_cnt_reg == POR_CYC - 12'h001) begin
						state_reg <= ST_IDLE;
					end
				end
				ST_SHUT: begin
					state_reg <= ST_IDLE;
				end
				ST_IDLE, ST_EXT, ST_INT: begin
					if (conv_go) begin
						state_reg <= use_ext ? ST_EXT : ST_INT;
					end else if (start_bit && rearm_reg) begin
						state_reg <= ST_IDLE;
					end else if (done_ev) begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			rearm_reg <= 1'b0;
		end else if (cs_rise && (state_reg == ST_EXT || state_reg == ST_INT)) begin
			rearm_reg <= 1'b1;
		end else if (start_bit || conv_go) begin
			rearm_reg <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			div_cnt_reg <= 10'h000;
		end else if (conv_go || tick || state_reg != ST_INT) begin
			div_cnt_reg <= 10'h000;
		end else begin
			div_cnt_reg <= div_cnt_reg + 10'h001;
		end
	end

	// sar decisions; comparator_i answers for the current trial code
	always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			sar_trial_o  <= '0;
			conv_cnt_reg <= 4'h0;
		end else if (conv_go) begin
			sar_trial_o  <= {1'b1, {(SAR_BITS - 1){1'b0}}};
			conv_cnt_reg <= 4'h0;
		end else if (step_ev) begin
			sar_trial_o  <= sar_step(sar_trial_o, conv_cnt_reg, comparator_i);
			conv_cnt_reg <= conv_cnt_reg + 4'h1;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			mux_pos_o     <= 2'h0;
			mux_neg_o     <= 2'h0;
			mux_neg_com_o <= 1'b1;
			unipolar_o    <= 1'b1;
		end else if (conv_go) begin
			{mux_pos_o, mux_neg_o, mux_neg_com_o} <= chan(ctrl_reg[SEL_MSB:SEL_LSB],
			                                             ctrl_reg[CFG_POS]);
			unipolar_o <= ctrl_reg[POL_POS];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// modes and power

	always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			ext_mode_reg      <= 1'b0;
			pd_req_reg        <= 1'b0;
			full_power_down_o <= 1'b0;
			fast_power_down_o <= 1'b0;
			hw_shutdown_o     <= 1'b0;
			comp_internal_o   <= 1'b0;
			int_clock_mode_o  <= 1'b1;
		end else begin
			hw_shutdown_o    <= ~shutdown_pin_n_n_s;
			comp_internal_o  <= ~float_s;
			int_clock_mode_o <= ~ext_mode_reg;
			if (conv_go) begin
				ext_mode_reg <= use_ext;
				pd_req_reg   <= ~ctrl_reg[1];
			end
			if (start_bit) begin
				full_power_down_o <= 1'b0;
				fast_power_down_o <= 1'b0;
			end
			// power-down only after the conversion ends; interface stays alive
			if (done_ev && pd_req_reg) begin
				full_power_down_o <= (ctrl_reg[1:0] == PD_FULL);
				fast_power_down_o <= (ctrl_reg[1:0] == PD_FAST);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// serial output

	always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			dout_o        <= 1'b0;
			out_shift_reg <= '0;
			out_cnt_reg   <= 5'h00;
		end else if (conv_go) begin
			dout_o        <= 1'b0;
			out_shift_reg <= '0;
			out_cnt_reg   <= 5'h00;
		end else if (state_reg == ST_EXT && step_ev) begin
			dout_o <= (conv_cnt_reg == 4'h0) ? comparator_i ^ ~unipolar_o : comparator_i;
			out_cnt_reg <= out_cnt_reg + 5'h01;
		end else if (state_reg == ST_INT && done_ev) begin
			out_shift_reg <= {fmt(sar_step(sar_trial_o, conv_cnt_reg, comparator_i),
			                  unipolar_o), 4'h0};
		end else if (sclk_fall && !cs_n_s) begin
			dout_o        <= out_shift_reg[FRAME_BITS-1];
			out_shift_reg <= {out_shift_reg[FRAME_BITS-2:0], 1'b0};
			if (out_cnt_reg != 5'h1f) begin
				out_cnt_reg <= out_cnt_reg + 5'h01;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			dout_oe_o <= 1'b0;
		end else begin
			dout_oe_o <= ~cs_n_s & shutdown_pin_n_n_s;
		end
	end

	// strobe: pulse in external mode, busy-low in internal mode
	always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			serial_strobe_o    <= 1'b1;
			serial_strobe_oe_o <= 1'b1;
		end else if (!shutdown_pin_n_n_s) begin
			serial_strobe_oe_o <= 1'b0;
		end else begin
			serial_strobe_oe_o <= (conv_go ? use_ext : ext_mode_reg) ? ~cs_n_s : 1'b1;
			if (conv_go) begin
				serial_strobe_o <= use_ext;
			end else if (state_reg == ST_EXT && sclk_fall) begin
				serial_strobe_o <= 1'b0;
			end else if (state_reg == ST_INT && done_ev) begin
				serial_strobe_o <= 1'b1;
			end else if (cs_fall && ext_mode_reg) begin
				serial_strobe_o <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	logic [11:0] int_low_cnt_reg;

	always_ff @(posedge core_clk_i or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			int_low_cnt_reg <= 12'h000;
		end else if (state_reg == ST_INT && !conv_go) begin
			int_low_cnt_reg <= int_low_cnt_reg + 12'h001;
		end else begin
			int_low_cnt_reg <= 12'h000;
		end
	end

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_reg);

	a_diff_pair_map: assert property (conv_go && !ctrl_reg[CFG_POS] && ctrl_reg[6:4] == 3'h5
		|=> mux_pos_o == 2'h1 && mux_neg_o == 2'h0 && !mux_neg_com_o)
		else $error("differential pairing wrong");
	a_ext_strobe_rise: assert property (conv_go && use_ext |=> serial_strobe_o)
		else $error("external strobe not raised at start");
	a_ext_strobe_pulse: assert property (state_reg == ST_EXT && serial_strobe_o && !sclk_fall
		&& !cs_fall |=> serial_strobe_o)
		else $error("external strobe dropped early");
	a_ext_strobe_one: assert property (state_reg == ST_EXT && sclk_fall && !conv_go
		|=> !serial_strobe_o)
		else $error("external strobe longer than one period");
	a_int_strobe_low: assert property (conv_go && !use_ext && shutdown_pin_n_n_s
		|=> !serial_strobe_o ##0 state_reg == ST_INT)
		else $error("internal strobe not low at start");
	a_int_low_bound: assert property (state_reg == ST_INT && float_s
		|-> int_low_cnt_reg < INT_LOW_MAX_CYC)
		else $error("internal conversion too long");
	a_int_strobe_drv: assert property (!ext_mode_reg && shutdown_pin_n_n_s && !conv_go
		|=> serial_strobe_oe_o)
		else $error("internal mode strobe released");
	a_cs_tristate: assert property (cs_n_s |=> !dout_oe_o)
		else $error("serial output driven while deselected");
	a_shutdown_pin_n_force: assert property (!shutdown_pin_n_n_s |=> state_reg == ST_SHUT && !rx_active_reg)
		else $error("shutdown pin not obeyed");
	a_por_quiet: assert property (state_reg == ST_POR |-> !launch_reg && serial_strobe_o)
		else $error("activity during reset interval");
	a_din_sample: assert property (accept_rx && rx_active_reg
		|=> ctrl_reg[0] == $past(din_s))
		else $error("input bit not captured on rise");

	c_ext_conv: cover property (state_reg == ST_EXT && done_ev);
	c_int_conv: cover property (state_reg == ST_INT && done_ev);
	c_rearm: cover property (rearm_reg && start_bit);
	c_power_down: cover property (done_ev && pd_req_reg);

endmodule

// File: hw/adcsc_pin_sync.sv
// Purpose: three flop pin synchroniser with agreement filter
// Assumes: inputs asynchronous to core_clk_i
// Notes:   a change counts once stages two and three agree
`timescale 1ns/1ps
module adcsc_pin_sync #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_reg <= RST_VAL;
			s2_reg <= RST_VAL;
			s3_reg <= RST_VAL;
			q_o    <= RST_VAL;
		end else begin
			s1_reg <= d_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			q_o    <= (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & q_o);
		end
	end

endmodule

// File: hw/adcsc_pkg.sv
// Purpose: constants and types for the serial conversion control block
// Assumes: 200 MHz core clock, serial clock well below it
// Notes:   field positions follow the control byte, msb first
//
// Contract
// - differential codes pair inputs as documented
// - result: zero, ten bits, two sub-bits, zeros
// - unipolar straight binary, bipolar twos complement
// - output bits change after serial clock fall
// - host clock shifts; track during last three bits
// - external: strobe one period, twelve decisions follow
// - external: outputs release on deselect, strobe low
// - internal: strobe low converting, bounded low time; bound met only with the shutdown pin floating
// - internal: result held, msb on next fall
// - internal: deselect blocks input, strobe stays driven
// - start bit when idle or after output bit seven
// - conversion starts on fall after eighth bit
// - deselect toggle rearms start, aborts conversion
// - back to back frames with select held low
// - power up internal mode, quiet reset interval
// - shutdown pin low forces full shutdown
// - software power-down keeps serial interface alive
// - floating shutdown pin selects external compensation
// - control byte field order start to mode
// - mode bits pick power-down or clock mode
// - input sampled on serial clock rise
// - power-down waits for current conversion end
package adcsc_pkg;

	localparam int CLK_MHZ     = 200;
	localparam int CTRL_BITS   = 8;
	localparam int POL_POS     = 3;
	localparam int CFG_POS     = 2;
	localparam int SEL_MSB     = 6;
	localparam int SEL_LSB     = 4;
	localparam int TRACK_FROM  = 5;
	localparam int SAR_BITS    = 12;
	localparam int FRAME_BITS  = 16;
	localparam int REARM_BITS  = 7;

	localparam logic [1:0] PD_FULL = 2'h0;
	localparam logic [1:0] PD_FAST = 2'h1;
	localparam logic [1:0] PD_INT  = 2'h2;
	localparam logic [1:0] PD_EXT  = 2'h3;

	// reset interval, least time
	localparam int         POR_TIME_NS = 10000;
	localparam logic [11:0] POR_CYC    = 12'((POR_TIME_NS * CLK_MHZ + 999) / 1000);

	// internal conversion clock; rounding down keeps it no slower than nominal
	localparam int         INT_FREQ_FLOAT_KHZ = 1800;
	localparam int         INT_FREQ_HIGH_KHZ  = 225;
	localparam logic [9:0] INT_DIV_FLOAT      = 10'(CLK_MHZ * 1000 / INT_FREQ_FLOAT_KHZ);
	localparam logic [9:0] INT_DIV_HIGH       = 10'(CLK_MHZ * 1000 / INT_FREQ_HIGH_KHZ);

	localparam int          INT_LOW_MAX_NS  = 7500;
	localparam logic [11:0] INT_LOW_MAX_CYC = 12'(INT_LOW_MAX_NS * CLK_MHZ / 1000);

	typedef enum logic [2:0] {
		ST_POR,
		ST_IDLE,
		ST_EXT,
		ST_INT,
		ST_SHUT
	} adcsc_state_t;

endpackage
